// ===== bench/prc_cfg_master.sv
`timescale 1ns/10ps
`default_nettype none
module prc_cfg_master (
    // Clock
    input wire logic coreClk,
    // Requests to the register port
    output logic [prc_pkg::ADDR_W-1:0] address,
    output logic read,
    output logic write,
    output logic [prc_pkg::DATA_W-1:0] writeData,
    output logic [1:0] byteEnable,
    // Answers from the register port
    input wire logic [prc_pkg::DATA_W-1:0] readData,
    input wire logic readDataValid,
    input wire logic waitRequest
);
    initial begin
        address = '0;
        read = 1'b0;
        write = 1'b0;
        writeData = '0;
        byteEnable = '0;
    end

    // ==========================================================
    // Bus cycles
    // A request is held until an edge sees the wait request low, for at most eight edges.
    task automatic hold(output logic ok);
        ok = 1'b0;
        for (int i = 0; i < 8 && !ok; i++) begin
            @(posedge coreClk);
            ok = (waitRequest === 1'b0);
        end
        #1;
    endtask : hold

    task automatic wr(input logic [9:0] a, input logic [15:0] d, input logic [1:0] be,
                      output logic ok);
        @(posedge coreClk);
        #1;
        address = a;
        writeData = d;
        byteEnable = be;
        write = 1'b1;
        hold(ok);
        write = 1'b0;
        // Released lanes carry junk, so the design cannot lean on stale data.
        writeData = ~d;
        byteEnable = ~be;
    endtask : wr

    task automatic rd(input logic [9:0] a, output logic [15:0] d, output logic ok);
        @(posedge coreClk);
        #1;
        address = a;
        read = 1'b1;
        hold(ok);
        read = 1'b0;
        d = readData;
        for (int i = 0; i < 4 && ok && readDataValid !== 1'b1; i++) begin
            @(posedge coreClk);
            #1;
            d = readData;
        end
        ok = ok && (readDataValid === 1'b1);
    endtask : rd
endmodule : prc_cfg_master
`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic coreClk = 1'b0;
    logic resetn = 1'b0;
    logic [prc_pkg::ADDR_W-1:0] addr;
    logic rdReq, wrReq, rdValid, waitReq;
    logic [prc_pkg::DATA_W-1:0] wData, rData;
    logic [1:0] be;
    prc_pkg::prc_caps_t caps;
    prc_pkg::prc_caps_t capsDown;
    logic [prc_pkg::DATA_W-1:0] rDataDown;
    int n_errors = 0;
    int compares = 0;

    always #5 coreClk = ~coreClk;

    prc_capability_regs dut (.coreClk(coreClk), .resetn(resetn), .reconfAddress(addr),
        .reconfRead(rdReq), .reconfWrite(wrReq), .reconfWriteData(wData),
        .reconfByteEnable(be), .reconfReadData(rData), .reconfReadDataValid(rdValid),
        .reconfWaitRequest(waitReq), .caps(caps));
    prc_cfg_master m (.coreClk(coreClk), .address(addr), .read(rdReq), .write(wrReq),
        .writeData(wData), .byteEnable(be), .readData(rData), .readDataValid(rdValid),
        .waitRequest(waitReq));
    // A downstream copy listens to the same bus so the port-role bits are exercised.
    prc_capability_regs #(.IS_DOWNSTREAM(1'b1)) dutDown (.coreClk(coreClk), .resetn(resetn),
        .reconfAddress(addr), .reconfRead(rdReq), .reconfWrite(wrReq), .reconfWriteData(wData),
        .reconfByteEnable(be), .reconfReadData(rDataDown), .reconfReadDataValid(),
        .reconfWaitRequest(), .caps(capsDown));

    // ==========================================================
    // Checks and bus helpers
    // These rebuild the VC and device words from the fields handed to the core.
    function automatic logic [15:0] vc_of(input prc_pkg::prc_caps_t c);
        return {c.rejectSnoop, c.vcArbCaps, c.lowPrioVc, c.aerCap};
    endfunction : vc_of

    function automatic logic [15:0] dev_of(input prc_pkg::prc_caps_t c);
        return {c.roleBasedErr, c.slotIndicators, c.l1Latency, c.l0sLatency, c.extTagCap,
            c.linkLayerUpStateCap, c.surpriseDownCap, c.maxPayload};
    endfunction : dev_of

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish

    task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_word

    task automatic bus_lost(input logic ok);
        if (!ok) begin
            n_errors++;
            $display("mismatch at %0t: bus cycle timed out", $time);
            tally_and_finish();
        end
    endtask : bus_lost

    task automatic wr(input logic [9:0] a, input logic [15:0] d, input logic [1:0] b);
        logic ok;
        m.wr(a, d, b, ok);
        bus_lost(ok);
    endtask : wr

    task automatic rd_chk(input logic [9:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic ok;
        m.rd(a, d, ok);
        bus_lost(ok);
        check_word(d, exp);
    endtask : rd_chk

    // ==========================================================
    // Test sequence
    initial begin
        repeat (16) @(posedge coreClk);
        #1;
        resetn = 1'b1;
        rd_chk(10'h000, 16'h0001);
        rd_chk(10'h090, 16'h0010);
        rd_chk(10'h091, 16'h8002);
        rd_chk(10'h092, 16'h0000);
        check_word({13'h0, caps.maxPayload}, 16'h0002);
        check_word(dev_of(caps), 16'h8002);
        check_word(vc_of(caps), 16'h0010);
        check_word(dev_of(capsDown), 16'h8002);
        check_word({15'h0, caps.reconfigEnable}, 16'h0000);
        wr(10'h091, 16'hffe5, 2'h3);
        rd_chk(10'h091, 16'h8002);
        $display("test defaults done");
        wr(10'h000, 16'h0000, 2'h3);
        check_word({15'h0, caps.reconfigEnable}, 16'h0001);
        wr(10'h091, 16'hfffd, 2'h3);
        rd_chk(10'h091, 16'hffe5);
        check_word(dev_of(caps), 16'hffe5);
        check_word(rDataDown, 16'hfffd);
        check_word(dev_of(capsDown), 16'hfffd);
        check_word({13'h0, caps.l0sLatency}, 16'h0007);
        check_word({13'h0, caps.l1Latency}, 16'h0007);
        check_word({13'h0, caps.slotIndicators}, 16'h0007);
        wr(10'h091, 16'h8006, 2'h3);
        rd_chk(10'h091, 16'h8005);
        check_word(rDataDown, 16'h8005);
        wr(10'h091, 16'h8007, 2'h3);
        rd_chk(10'h091, 16'h8005);
        wr(10'h092, 16'hffff, 2'h3);
        rd_chk(10'h092, 16'h0003);
        wr(10'h090, 16'h12ab, 2'h1);
        rd_chk(10'h090, 16'h00ab);
        check_word(vc_of(caps), 16'h00ab);
        check_word({14'h0, caps.slotPowerScale}, 16'h0003);
        wr(10'h055, 16'h1234, 2'h3);
        rd_chk(10'h055, 16'h0000);
        $display("test reconfigure done");
        wr(10'h000, 16'h0001, 2'h3);
        rd_chk(10'h091, 16'h8002);
        rd_chk(10'h092, 16'h0000);
        rd_chk(10'h000, 16'h0001);
        check_word(vc_of(caps), 16'h0010);
        check_word(dev_of(capsDown), 16'h8002);
        $display("test restore done");
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire

// ===== logic/prc_capability_regs.sv
`timescale 1ns/10ps
`default_nettype none
module prc_capability_regs #(
    parameter bit IS_DOWNSTREAM = 1'b0
) (
    // Clock and reset
    input wire logic coreClk,
    input wire logic resetn,
    // Reconfiguration port
    input wire logic [prc_pkg::ADDR_W-1:0] reconfAddress,
    input wire logic reconfRead,
    input wire logic reconfWrite,
    input wire logic [prc_pkg::DATA_W-1:0] reconfWriteData,
    input wire logic [1:0] reconfByteEnable,
    output logic [prc_pkg::DATA_W-1:0] reconfReadData,
    output logic reconfReadDataValid,
    output logic reconfWaitRequest,
    // Capability fields to the core
    output var prc_pkg::prc_caps_t caps
);

    // ==========================================================
    // Elaboration checks
    // The lane mask assumes a word of exactly two byte lanes.
    if (prc_pkg::DATA_W != 16) begin : gLaneCheck
        $error("reconfiguration words must be two byte lanes wide");
    end

    // ==========================================================
    // Address decode
    logic modeReg;
    logic [prc_pkg::DATA_W-1:0] vcWord;
    logic [prc_pkg::DATA_W-1:0] devWord;
    logic [prc_pkg::DATA_W-1:0] slotWord;
    wire logic hitMode = reconfAddress == prc_pkg::ADDR_MODE;
    wire logic hitVc = reconfAddress == prc_pkg::ADDR_VC;
    wire logic hitDev = reconfAddress == prc_pkg::ADDR_DEV;
    wire logic hitSlot = reconfAddress == prc_pkg::ADDR_SLOT;
    wire logic [prc_pkg::DATA_W-1:0] laneMask = {{8{reconfByteEnable[1]}},
                                                {8{reconfByteEnable[0]}}};
    wire logic fieldWrite = reconfWrite && !modeReg;
    wire logic modeWrite = reconfWrite && hitMode && reconfByteEnable[0];

    // ==========================================================
    // Mode bit: one holds every field at its default.
    always_ff @(posedge coreClk) begin
        if (!resetn) begin
            modeReg <= prc_pkg::RST_MODE;
        end else if (modeWrite) begin
            modeReg <= reconfWriteData[prc_pkg::BIT_MODE];
        end
    end

    // ==========================================================
    // Write masks
    wire logic mpsReserved =
        reconfWriteData[prc_pkg::MPS_LSB +: 3] >= prc_pkg::MPS_RSVD_MIN;
    wire logic [prc_pkg::DATA_W-1:0] mpsKeep = mpsReserved ? prc_pkg::MPS_FIELD : '0;
    wire logic [prc_pkg::DATA_W-1:0] portKeep =
        IS_DOWNSTREAM ? '0 : prc_pkg::DOWNSTREAM_BITS;
    wire logic [prc_pkg::DATA_W-1:0] vcMask = prc_pkg::MASK_VC & laneMask;
    wire logic [prc_pkg::DATA_W-1:0] devMask =
        prc_pkg::MASK_DEV & laneMask & ~mpsKeep & ~portKeep;
    wire logic [prc_pkg::DATA_W-1:0] slotMask = prc_pkg::MASK_SLOT & laneMask;

    // ==========================================================
    // Register words
    prc_field_reg #(
        .WIDTH(prc_pkg::DATA_W),
        .RESET_VALUE(prc_pkg::RST_VC)
    ) uVcWord (
        .coreClk(coreClk),
        .resetn(resetn),
        .loadDefault(modeReg),
        .writeEn(fieldWrite && hitVc),
        .writeMask(vcMask),
        .writeData(reconfWriteData),
        .value(vcWord)
    );

    prc_field_reg #(
        .WIDTH(prc_pkg::DATA_W),
        .RESET_VALUE(prc_pkg::RST_DEV)
    ) uDevWord (
        .coreClk(coreClk),
        .resetn(resetn),
        .loadDefault(modeReg),
        .writeEn(fieldWrite && hitDev),
        .writeMask(devMask),
        .writeData(reconfWriteData),
        .value(devWord)
    );

    prc_field_reg #(
        .WIDTH(prc_pkg::DATA_W),
        .RESET_VALUE(prc_pkg::RST_SLOT)
    ) uSlotWord (
        .coreClk(coreClk),
        .resetn(resetn),
        .loadDefault(modeReg),
        .writeEn(fieldWrite && hitSlot),
        .writeMask(slotMask),
        .writeData(reconfWriteData),
        .value(slotWord)
    );

    // ==========================================================
    // Read path, fixed one-cycle latency; unmapped words read zero.
    wire logic [prc_pkg::DATA_W-1:0] readMux =
        hitMode ? {{(prc_pkg::DATA_W-1){1'b0}}, modeReg} :
        hitVc ? vcWord :
        hitDev ? devWord :
        hitSlot ? slotWord : '0;

    always_ff @(posedge coreClk) begin
        if (!resetn) begin
            reconfReadData <= '0;
            reconfReadDataValid <= 1'b0;
        end else begin
            reconfReadDataValid <= reconfRead;
            if (reconfRead) begin
                reconfReadData <= readMux;
            end
        end
    end

    assign reconfWaitRequest = 1'b0;

    // ==========================================================
    // Field fan-out to the core
    always_comb begin
        caps.reconfigEnable = !modeReg;
        caps.aerCap = vcWord[prc_pkg::BIT_AER];
        caps.lowPrioVc = vcWord[prc_pkg::LPVC_LSB +: 3];
        caps.vcArbCaps = vcWord[prc_pkg::VCARB_LSB +: 4];
        caps.rejectSnoop = vcWord[prc_pkg::SNOOP_LSB +: 8];
        caps.maxPayload = devWord[prc_pkg::MPS_LSB +: 3];
        caps.surpriseDownCap = devWord[prc_pkg::BIT_SURPRISE];
        caps.linkLayerUpStateCap = devWord[prc_pkg::BIT_LINKUP];
        caps.extTagCap = devWord[prc_pkg::BIT_EXTTAG];
        caps.l0sLatency = devWord[prc_pkg::L0S_LSB +: 3];
        caps.l1Latency = devWord[prc_pkg::L1_LSB +: 3];
        caps.slotIndicators = devWord[prc_pkg::IND_LSB +: 3];
        caps.roleBasedErr = devWord[prc_pkg::BIT_ROLE];
        caps.slotPowerScale = slotWord[prc_pkg::SCALE_LSB +: 2];
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge coreClk);
    endclocking
    default disable iff (!resetn);

    wire logic devLive = fieldWrite && hitDev;

    // Field behaviour on writes.
    a_mps_no_reserved: assert property (caps.maxPayload < prc_pkg::MPS_RSVD_MIN)
        else $error("payload field holds a reserved code");
    a_mps_refused: assert property (devLive && reconfByteEnable[0] && mpsReserved
        |=> caps.maxPayload == $past(caps.maxPayload))
        else $error("reserved payload code was stored");
    a_surprise_upstream: assert property (!IS_DOWNSTREAM |-> !caps.surpriseDownCap)
        else $error("surprise-down bit set on an upstream port");
    a_linkup_upstream: assert property (!IS_DOWNSTREAM |-> !caps.linkLayerUpStateCap)
        else $error("link-up reporting bit set on an upstream port");
    a_exttag_write: assert property (devLive && reconfByteEnable[0]
        |=> caps.extTagCap == $past(reconfWriteData[prc_pkg::BIT_EXTTAG]))
        else $error("extended tag bit did not take the written value");
    a_l0s_write: assert property (devLive && (reconfByteEnable == 2'b11)
        |=> caps.l0sLatency == $past(reconfWriteData[prc_pkg::L0S_LSB +: 3]))
        else $error("L0s latency did not take the written value");
    a_l1_write: assert property (devLive && reconfByteEnable[1]
        |=> caps.l1Latency == $past(reconfWriteData[prc_pkg::L1_LSB +: 3]))
        else $error("L1 latency did not take the written value");
    a_indicator_write: assert property (devLive && reconfByteEnable[1]
        |=> caps.slotIndicators == $past(reconfWriteData[prc_pkg::IND_LSB +: 3]))
        else $error("indicator bits did not take the written value");
    a_scale_write: assert property (fieldWrite && hitSlot && reconfByteEnable[0]
        |=> caps.slotPowerScale == $past(reconfWriteData[prc_pkg::SCALE_LSB +: 2])
            && (slotWord & ~prc_pkg::MASK_SLOT) == '0)
        else $error("slot power scale write went wrong");
    a_mode_restore: assert property (modeReg
        |=> devWord == prc_pkg::RST_DEV && vcWord == prc_pkg::RST_VC
            && slotWord == prc_pkg::RST_SLOT)
        else $error("defaults not restored while reconfiguration is off");
    a_mode_write: assert property (modeWrite
        |=> caps.reconfigEnable == !$past(reconfWriteData[prc_pkg::BIT_MODE]))
        else $error("mode bit did not take the written value");
    a_vc_write: assert property (fieldWrite && hitVc && (reconfByteEnable == 2'b11)
        |=> vcWord == $past(reconfWriteData))
        else $error("vc word did not take the written value");
    a_dev_hold: assert property (!modeReg && !devLive |=> $stable(devWord))
        else $error("device word changed without a write");
    a_slot_hold: assert property (!modeReg && !(fieldWrite && hitSlot) |=> $stable(slotWord))
        else $error("slot word changed without a write");

    // Read port timing.
    a_read_return: assert property (reconfRead && hitDev && !reconfWrite
        |=> reconfReadDataValid && reconfReadData == $past(devWord))
        else $error("read did not return the stored word");
    a_read_valid: assert property (reconfRead |=> reconfReadDataValid)
        else $error("read request got no valid pulse");
    a_read_quiet: assert property (!reconfRead |=> !reconfReadDataValid)
        else $error("valid pulse without a read request");

    // Scenarios worth seeing.
    c_enable_mode: cover property (modeWrite && !reconfWriteData[prc_pkg::BIT_MODE]);
    c_dev_write: cover property (devLive ##1 reconfRead && hitDev);
    c_restore: cover property (!modeReg ##1 modeReg);
    c_reserved_code: cover property (devLive && reconfByteEnable[0] && mpsReserved);
    c_lane_write: cover property (fieldWrite && hitVc && reconfByteEnable == 2'b01);

endmodule : prc_capability_regs
`default_nettype wire

// ===== logic/prc_field_reg.sv
`timescale 1ns/10ps
`default_nettype none
module prc_field_reg #(
    parameter int WIDTH = 16,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // Clock and reset
    input wire logic coreClk,
    input wire logic resetn,
    // Control
    input wire logic loadDefault,
    input wire logic writeEn,
    input wire logic [WIDTH-1:0] writeMask,
    input wire logic [WIDTH-1:0] writeData,
    // Contents
    output logic [WIDTH-1:0] value
);

    logic [WIDTH-1:0] next_value;

    if (WIDTH < 1) begin : gWidthCheck
        $error("prc_field_reg width must be positive");
    end

    assign next_value = (value & ~writeMask) | (writeData & writeMask);

    always_ff @(posedge coreClk) begin
        if (!resetn || loadDefault) begin
            value <= RESET_VALUE;
        end else if (writeEn) begin
            value <= next_value;
        end
    end

endmodule : prc_field_reg
`default_nettype wire

// ===== logic/prc_pkg.sv
package prc_pkg;

    // ==========================================================
    // Bus geometry
    localparam int ADDR_W = 10;
    localparam int DATA_W = 16;

    // ==========================================================
    // Word indices on the reconfiguration port
    localparam logic [ADDR_W-1:0] ADDR_MODE = 10'h000;
    localparam logic [ADDR_W-1:0] ADDR_VC = 10'h090;
    localparam logic [ADDR_W-1:0] ADDR_DEV = 10'h091;
    localparam logic [ADDR_W-1:0] ADDR_SLOT = 10'h092;

    // ==========================================================
    // Reset values and writable masks
    localparam logic RST_MODE = 1'b1;
    localparam logic [DATA_W-1:0] RST_VC = 16'h0010;
    localparam logic [DATA_W-1:0] RST_DEV = 16'h8002;
    localparam logic [DATA_W-1:0] RST_SLOT = 16'h0000;
    localparam logic [DATA_W-1:0] MASK_VC = 16'hffff;
    localparam logic [DATA_W-1:0] MASK_DEV = 16'hffff;
    localparam logic [DATA_W-1:0] MASK_SLOT = 16'h0003;

    // ==========================================================
    // Field positions
    localparam int BIT_MODE = 0;
    localparam int BIT_AER = 0;
    localparam int LPVC_LSB = 1;
    localparam int VCARB_LSB = 4;
    localparam int SNOOP_LSB = 8;
    localparam int MPS_LSB = 0;
    localparam int BIT_SURPRISE = 3;
    localparam int BIT_LINKUP = 4;
    localparam int BIT_EXTTAG = 5;
    localparam int L0S_LSB = 6;
    localparam int L1_LSB = 9;
    localparam int IND_LSB = 12;
    localparam int BIT_ROLE = 15;
    localparam int SCALE_LSB = 0;

    // Payload codes at or above this value are reserved.
    localparam logic [2:0] MPS_RSVD_MIN = 3'h6;
    localparam logic [DATA_W-1:0] MPS_FIELD = 16'h0007;
    localparam logic [DATA_W-1:0] DOWNSTREAM_BITS = 16'h0018;

    // ==========================================================
    // Capability fields as presented to the core
    typedef struct packed {
        logic reconfigEnable;
        logic aerCap;
        logic [2:0] lowPrioVc;
        logic [3:0] vcArbCaps;
        logic [7:0] rejectSnoop;
        logic [2:0] maxPayload;
        logic surpriseDownCap;
        logic linkLayerUpStateCap;
        logic extTagCap;
        logic [2:0] l0sLatency;
        logic [2:0] l1Latency;
        logic [2:0] slotIndicators;
        logic roleBasedErr;
        logic [1:0] slotPowerScale;
    } prc_caps_t;

endpackage : prc_pkg
